// [src/msr_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "msr_consts.svh"
module msr_bank #(
	parameter logic [63:0] MTYPE_CAP = 64'h0000_0000_0000_0000,
	parameter logic [63:0] GCHK_CAP  = 64'h0000_0000_0000_0000,
	parameter int          CTR_W     = 64
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire msr_pkg::req_s      req,
	output msr_pkg::ans_s           ans,
	input  wire msr_pkg::strap_s    strap_pins,
	input  wire logic [63:0]        legacy_addr_in,
	input  wire logic [63:0]        legacy_type_in,
	input  wire logic [1:0]         cpl,
	input  wire msr_pkg::event_in_s ev0,
	input  wire msr_pkg::event_in_s ev1,
	input  wire logic [1:0]         bp_match,
	output logic [1:0]              bp_pin,
	output logic [1:0]              perf_intc_req,
	output logic                    intc_enable,
	output logic [7:0]              bus_cfg_ctl,
	output logic                    lbr_enable,
	output logic                    branch_trap,
	output logic                    fw_update_pulse,
	output logic [63:0]             fw_update_addr,
	output logic [63:0]             gchk_ctl
);
	import msr_pkg::*;

	strap_s       strap_meta;
	strap_s       strap_sync;
	strap_s       strap;
	logic         strap_taken;
	logic [63:0]  time_stamp_counter;
	logic [31:0]  bus_cfg_rw;
	logic [63:0]  fw_sign;
	logic [63:0]  gchk_stat;
	evtsel_s      evsel [2];
	logic [31:0]  dbg;
	logic [CTR_W-1:0] ctr [2];
	logic [1:0]   ovf;
	logic [1:0]   ctr_wr;
	event_in_s    ev [2];
	logic [63:0]  rd_data;
	logic         known;
	logic         ro;
	logic         wo;
	logic         fault;
	logic         wr_ok;
	logic [31:0]  bus_cfg_view;

	assign ev[0] = ev0;
	assign ev[1] = ev1;

	// power-on straps come from pins: two flops before use
	always_ff @(posedge clk_sys) begin
		strap_meta <= strap_pins;
		strap_sync <= strap_meta;
	end

	// straps are caught once, on the first cycle after reset release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_taken <= 1'b0;
			strap       <= '0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			strap       <= strap_sync;
		end
	end

	always_comb begin
		bus_cfg_view        = bus_cfg_rw & `BUS_CFG_WMASK;
		bus_cfg_view[8]     = strap.tristate;
		bus_cfg_view[9]     = strap.bist;
		bus_cfg_view[10]    = strap.address_error_signal_obs;
		bus_cfg_view[12]    = strap.bus_initialise_signal_obs;
		bus_cfg_view[13]    = strap.ioq_one;
		bus_cfg_view[14]    = strap.vec_1m;
		bus_cfg_view[15]    = strap.redundancy_check_mode;
		bus_cfg_view[17:16] = strap.cluster_id;
		bus_cfg_view[21:20] = strap.arb_id;
		bus_cfg_view[24:22] = strap.clk_ratio;
		bus_cfg_view[26]    = strap.low_power;
	end

	// address decode: read value and access class per address
	always_comb begin
		rd_data = 64'h0000_0000_0000_0000;
		known   = 1'b1;
		ro      = 1'b0;
		wo      = 1'b0;
		unique case (req.addr)
			`A_LEGACY_ADDR: begin
				rd_data = legacy_addr_in;
				ro      = 1'b1;
			end
			`A_LEGACY_TYPE: begin
				rd_data = legacy_type_in;
				ro      = 1'b1;
			end
			`A_TSC: begin
				rd_data = time_stamp_counter;
			end
			`A_INTC_BASE: begin
				rd_data[`INTC_BSP_BIT] = strap.bootstrap_processor_flag;
				rd_data[`INTC_EN_BIT]  = intc_enable;
			end
			`A_BUS_CFG: begin
				rd_data[31:0] = bus_cfg_view;
			end
			`A_FW_TRIG: begin
				wo = 1'b1;
			end
			`A_FW_SIGN: begin
				rd_data = fw_sign;
			end
			`A_CTR0: begin
				rd_data = 64'(ctr[0]);
			end
			`A_CTR1: begin
				rd_data = 64'(ctr[1]);
			end
			`A_MTYPE_CAP: begin
				rd_data = MTYPE_CAP;
				ro      = 1'b1;
			end
			`A_GCHK_CAP: begin
				rd_data = GCHK_CAP;
				ro      = 1'b1;
			end
			`A_GCHK_STAT: begin
				rd_data = gchk_stat;
			end
			`A_GCHK_CTL: begin
				rd_data = gchk_ctl;
			end
			`A_EVSEL0: begin
				rd_data[31:0] = evsel[0];
			end
			`A_EVSEL1: begin
				rd_data[31:0] = evsel[1];
				rd_data[22]   = 1'b0;
			end
			`A_DEBUG_CTL: begin
				rd_data[31:0] = dbg;
			end
			default: begin
				known = 1'b0;
			end
		endcase
		// unmapped, writes to read-only and reads of write-only all fault
		fault = !known || (req.wr && ro) || (req.rd && wo);
		wr_ok = req.wr && !fault;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ans <= '0;
		end else begin
			ans.valid <= req.rd || req.wr;
			ans.fault <= (req.rd || req.wr) && fault;
			ans.rdata <= (req.rd && !fault) ? rd_data : 64'h0000_0000_0000_0000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			time_stamp_counter <= 64'h0000_0000_0000_0000;
		end else if (wr_ok && req.addr == `A_TSC) begin
			time_stamp_counter <= req.wdata;
		end else begin
			time_stamp_counter <= time_stamp_counter + 64'h0000_0000_0000_0001;
		end
	end

	// the enable can only fall; nothing but reset brings it back
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			intc_enable <= 1'b1;
		end else if (wr_ok && req.addr == `A_INTC_BASE) begin
			intc_enable <= intc_enable & req.wdata[`INTC_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_cfg_rw <= `BUS_CFG_RST;
		end else if (wr_ok && req.addr == `A_BUS_CFG) begin
			bus_cfg_rw <= req.wdata[31:0] & `BUS_CFG_WMASK;
		end
	end
	assign bus_cfg_ctl = bus_cfg_view[7:0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fw_update_pulse <= 1'b0;
			fw_update_addr  <= 64'h0000_0000_0000_0000;
		end else begin
			fw_update_pulse <= wr_ok && req.addr == `A_FW_TRIG;
			if (wr_ok && req.addr == `A_FW_TRIG) begin
				fw_update_addr <= req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fw_sign   <= 64'h0000_0000_0000_0000;
			gchk_stat <= 64'h0000_0000_0000_0000;
			gchk_ctl  <= 64'h0000_0000_0000_0000;
		end else if (wr_ok) begin
			if (req.addr == `A_FW_SIGN) begin
				fw_sign <= req.wdata;
			end
			if (req.addr == `A_GCHK_STAT) begin
				gchk_stat <= req.wdata;
			end
			if (req.addr == `A_GCHK_CTL) begin
				gchk_ctl <= req.wdata;
			end
		end
	end

	// second selector has no master enable of its own
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			evsel[0] <= '0;
			evsel[1] <= '0;
		end else if (wr_ok) begin
			if (req.addr == `A_EVSEL0) begin
				evsel[0] <= req.wdata[31:0];
			end
			if (req.addr == `A_EVSEL1) begin
				evsel[1]    <= req.wdata[31:0];
				evsel[1].en <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dbg <= 32'h0000_0000;
		end else if (wr_ok && req.addr == `A_DEBUG_CTL) begin
			dbg <= req.wdata[31:0] & `DBG_WMASK;
		end
	end
	assign lbr_enable  = dbg[0];
	assign branch_trap = dbg[1];

	assign ctr_wr[0] = wr_ok && req.addr == `A_CTR0;
	assign ctr_wr[1] = wr_ok && req.addr == `A_CTR1;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_ctr
			perf_counter_unit #(
				.WIDTH (CTR_W)
			) u_ctr (
				.clk_sys   (clk_sys),
				.rst       (rst),
				.sel       (evsel[i]),
				.master_en (evsel[0].en),
				.cpl       (cpl),
				.ev        (ev[i]),
				.wr_en     (ctr_wr[i]),
				.wr_data   (req.wdata[CTR_W-1:0]),
				.count     (ctr[i]),
				.ovf       (ovf[i])
			);

			// pin shows either the overflow or the breakpoint match
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					bp_pin[i] <= 1'b0;
				end else if (dbg[2 + i]) begin
					bp_pin[i] <= ovf[i] && evsel[i].pin;
				end else begin
					bp_pin[i] <= bp_match[i];
				end
			end

			// a disabled controller takes no overflow input
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					perf_intc_req[i] <= 1'b0;
				end else begin
					perf_intc_req[i] <= ovf[i] && evsel[i].intr && intc_enable;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [src/msr_consts.svh]
// What this block does
// - every register is read or written by numeric address; each address decodes to it
// - interrupt-controller base bit 8 reads 1 on the bootstrap processor, else 0
// - base bit 11 enables the interrupt controller; once cleared it stays off until reset
// - bus config bit 0 picks ecc (1) or parity (0); read/write
// - bus config bits 1 and 2 disable data and response checking when 1
// - bus config bits 3,4,6,7 disable their driver or error signal when 1
// - bus config bits 8,9,10,12 are read-only power-on enables, 1 means enabled
// - bus config bit 13 reads queue depth: 1 means depth 1, 0 means 8
// - bus config bit 14 reads reset vector place: 1 below 1M, 0 below 4G
// - bus config bit 15 reads whether redundancy check mode was on at power-on
// - selector bits 7:0 hold an event code that no logic decodes, bits 15:8 qualify the event, zero blocks cache events and other agents' bus events
// - selector bit 16 counts at levels 1-3, bit 17 counts at level 0
// - selector bit 18, with a zero threshold: 1 counts occurrences, 0 counts active cycles
// - selector bit 19 signals counter overflow on the breakpoint pin of the same number
// - selector bit 20 raises counter overflow as interrupt-controller input
// - first selector bit 22 starts or stops counting in both counters
// - selector bits 31:24 hold a threshold; bit 23 inverts its comparison
// - debug bit 0 enables last branch recording; bit 1 controls branch trap
// - debug bits 2 and 3 make each dual-use pin show counter or breakpoint
// - cache events count only lines whose state bit is set in qualifier bits 3:0
// - bus events count own transactions when qualifier bit 5 is 0, all when 1
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH
`define A_LEGACY_ADDR 32'h0000_0000
`define A_LEGACY_TYPE 32'h0000_0001
`define A_TSC         32'h0000_0010
`define A_INTC_BASE   32'h0000_001B
`define A_BUS_CFG     32'h0000_002A
`define A_FW_TRIG     32'h0000_0079
`define A_FW_SIGN     32'h0000_008B
`define A_CTR0        32'h0000_00C1
`define A_CTR1        32'h0000_00C2
`define A_MTYPE_CAP   32'h0000_00FE
`define A_GCHK_CAP    32'h0000_0179
`define A_GCHK_STAT   32'h0000_017A
`define A_GCHK_CTL    32'h0000_017B
`define A_EVSEL0      32'h0000_0186
`define A_EVSEL1      32'h0000_0187
`define A_DEBUG_CTL   32'h0000_01D9
`define INTC_BSP_BIT  8
`define INTC_EN_BIT   11
`define BUS_CFG_WMASK 32'h0000_00DF
`define BUS_CFG_RST   32'h0000_0000
`define DBG_WMASK     32'h0000_000F
`endif

// [src/msr_pkg.sv]
package msr_pkg;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [31:0] addr;
		logic [63:0] wdata;
	} req_s;
	typedef struct packed {
		logic        valid;
		logic        fault;
		logic [63:0] rdata;
	} ans_s;
	typedef struct packed {
		logic [7:0] threshold_field;
		logic       threshold_invert;
		logic       en;
		logic       rsvd;
		logic       intr;
		logic       pin;
		logic       edge_mode;
		logic       os;
		logic       usr;
		logic [7:0] unit_qualifier_field;
		logic [7:0] code;
	} evtsel_s;
	typedef struct packed {
		logic       is_cache;
		logic [3:0] line_state;
		logic       is_bus;
		logic       from_self;
		logic [7:0] count;
	} event_in_s;
	typedef struct packed {
		logic       low_power;
		logic [2:0] clk_ratio;
		logic [1:0] arb_id;
		logic [1:0] cluster_id;
		logic       redundancy_check_mode;
		logic       vec_1m;
		logic       ioq_one;
		logic       bus_initialise_signal_obs;
		logic       address_error_signal_obs;
		logic       bist;
		logic       tristate;
		logic       bootstrap_processor_flag;
	} strap_s;
endpackage

// [src/perf_counter_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module perf_counter_unit #(
	parameter int WIDTH = 64
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire msr_pkg::evtsel_s sel,
	input  wire logic             master_en,
	input  wire logic [1:0]       cpl,
	input  wire msr_pkg::event_in_s ev,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0]      count,
	output logic                  ovf
);
	import msr_pkg::*;
	logic [7:0]       q;
	logic             priv_ok;
	logic             thr_ok;
	logic [7:0]       step;
	logic [WIDTH:0]   sum;

	always_comb begin
		q = ev.count;
		if (ev.is_cache && (ev.line_state & sel.unit_qualifier_field[3:0]) == 4'h0) begin
			q = 8'h00;
		end
		if (ev.is_bus && !sel.unit_qualifier_field[5] && !ev.from_self) begin
			q = 8'h00;
		end
		priv_ok = (cpl == 2'h0) ? sel.os : sel.usr;
		// a zero threshold leaves every cycle eligible
		thr_ok = (sel.threshold_field == 8'h00) ? 1'b1 : ((q >= sel.threshold_field) ^ sel.threshold_invert);
		if (!(master_en && priv_ok && thr_ok)) begin
			step = 8'h00;
		end else if (sel.threshold_field != 8'h00) begin
			step = 8'h01;
		end else if (sel.edge_mode) begin
			step = q;
		end else begin
			step = {7'h00, q != 8'h00};
		end
		sum = {1'b0, count} + {{(WIDTH - 7){1'b0}}, step};
	end

	// a software write wins over a count in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= '0;
		end else if (wr_en) begin
			count <= wr_data;
		end else begin
			count <= sum[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ovf <= 1'b0;
		end else begin
			ovf <= !wr_en && sum[WIDTH];
		end
	end
endmodule
`default_nettype wire

// [testbench/msr_bank_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module msr_bank_monitor (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire msr_pkg::req_s   req,
	input  wire msr_pkg::ans_s   ans,
	input  wire msr_pkg::strap_s strap_pins,
	input  wire logic [1:0]      bp_match,
	input  wire logic [1:0]      bp_pin,
	input  wire logic            intc_enable,
	input  wire logic [7:0]      bus_cfg_ctl,
	input  wire logic            lbr_enable,
	input  wire logic            branch_trap
);
	import msr_pkg::*;
	// shadow of debug bits 3:2, the design keeps its copy private
	logic [1:0] pin_mode;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_mode <= 2'b00;
		end else if (req.wr && req.addr == 32'h0000_01D9) begin
			pin_mode <= req.wdata[3:2];
		end
	end
	property p_answer; (req.rd || req.wr) |=> ans.valid; endproperty
	a_answer: assert property (p_answer) else $error("request got no answer");
	property p_quiet; !(req.rd || req.wr) |=> !ans.valid; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_wo_read; req.rd && req.addr == 32'h0000_0079 |=> ans.valid && ans.fault; endproperty
	a_wo_read: assert property (p_wo_read) else $error("write-only read not refused");
	property p_intc_stays; !intc_enable |=> !intc_enable; endproperty
	a_intc_stays: assert property (p_intc_stays) else $error("controller enabled again");
	property p_boot; req.rd && req.addr == 32'h0000_001B |=> ans.rdata[8] == strap_pins.bootstrap_processor_flag; endproperty
	a_boot: assert property (p_boot) else $error("boot flag wrong");
	property p_straps;
		req.rd && req.addr == 32'h0000_002A |=> ans.rdata[15:8] == {strap_pins.redundancy_check_mode, strap_pins.vec_1m,
			strap_pins.ioq_one, strap_pins.bus_initialise_signal_obs, 1'b0, strap_pins.address_error_signal_obs, strap_pins.bist, strap_pins.tristate};
	endproperty
	a_straps: assert property (p_straps) else $error("power-on bits wrong");
	property p_bus_ctl; req.wr && req.addr == 32'h0000_002A |=> bus_cfg_ctl == ($past(req.wdata[7:0]) & 8'hDF); endproperty
	a_bus_ctl: assert property (p_bus_ctl) else $error("bus control bits wrong");
	property p_debug_out;
		req.wr && req.addr == 32'h0000_01D9 |=> {branch_trap, lbr_enable} == $past(req.wdata[1:0]);
	endproperty
	a_debug_out: assert property (p_debug_out) else $error("debug outputs wrong");
	// mode that drove the pin is the one in force an edge earlier; a reset edge shows 0 instead
	property p_pin_follow; !$past(rst) && !$past(pin_mode[0]) |-> bp_pin[0] == $past(bp_match[0]); endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow match");
	c_disable: cover property (req.wr && req.addr == 32'h0000_001B && !req.wdata[11]);
	c_fault: cover property (ans.valid && ans.fault);
	c_ovf_pin: cover property (pin_mode[0] && bp_pin[0]);
endmodule
bind msr_bank msr_bank_monitor mon (.clk_sys(clk_sys), .rst(rst), .req(req), .ans(ans), .strap_pins(strap_pins),
	.bp_match(bp_match), .bp_pin(bp_pin), .intc_enable(intc_enable), .bus_cfg_ctl(bus_cfg_ctl),
	.lbr_enable(lbr_enable), .branch_trap(branch_trap));
`default_nettype wire

// [testbench/msr_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "msr_consts.svh"
module msr_bank_tb;
	import msr_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	req_s        req = '0;
	ans_s        ans;
	strap_s      strap_pins = 16'hD6AB;
	logic [1:0]  cpl = 2'b00;
	event_in_s   ev0 = '0;
	logic [1:0]  bp_match = 2'b00;
	logic [1:0]  bp_pin;
	logic [1:0]  perf_intc_req;
	logic        intc_enable;
	logic [7:0]  bus_cfg_ctl;
	logic        lbr_enable;
	logic        branch_trap;
	logic [63:0] gchk_ctl;
	logic [63:0] fw_update_addr;
	logic [63:0] q;
	logic        f;
	int          fail_count = 0;
	int          total_checks = 0;
	// 8-bit counters so a wrap is reached in a few cycles
	msr_bank #(.CTR_W(8)) dut (.clk_sys(clk_sys), .rst(rst), .req(req), .ans(ans), .strap_pins(strap_pins),
		.legacy_addr_in(64'h1234_5678_9ABC_DEF0), .legacy_type_in(64'h0FED_CBA9_8765_4321), .cpl(cpl),
		.ev0(ev0), .ev1('0), .bp_match(bp_match), .bp_pin(bp_pin), .perf_intc_req(perf_intc_req),
		.intc_enable(intc_enable), .bus_cfg_ctl(bus_cfg_ctl), .lbr_enable(lbr_enable),
		.branch_trap(branch_trap), .fw_update_pulse(), .fw_update_addr(fw_update_addr), .gchk_ctl(gchk_ctl));
	always #2 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic stop_test;
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// idle cycle after each access so req is never assigned twice in one step
	task automatic acc(input logic r, input logic [31:0] a, input logic [63:0] d);
		req = {r, !r, a, d};
		@(negedge clk_sys);
		req = '0;
		chk("answer valid", 1, ans.valid);
		q = ans.rdata;
		f = ans.fault;
		@(negedge clk_sys);
	endtask
	task automatic t_map;
		logic [31:0] fa [4] = '{32'h0003, `A_LEGACY_ADDR, `A_FW_TRIG, `A_MTYPE_CAP};
		logic [3:0]  fr = 4'b0101;
		logic [31:0] ra [3] = '{`A_FW_SIGN, `A_GCHK_STAT, `A_GCHK_CTL};
		acc(1, `A_INTC_BASE, 0);
		chk("intc base", 64'h0900, q);
		acc(1, `A_BUS_CFG, 0);
		chk("bus config", 64'h0552_A500, q);
		acc(1, `A_LEGACY_TYPE, 0);
		chk("legacy type", 64'h0FED_CBA9_8765_4321, q);
		acc(0, `A_TSC, 64'h0100);
		acc(1, `A_TSC, 0);
		chk("time stamp", 64'h0101, q);
		for (int i = 0; i < 4; i++) begin
			acc(fr[i], fa[i], 0);
			chk("fault", 1, f);
		end
		for (int i = 0; i < 3; i++) begin
			acc(1, ra[i], 0);
			chk("reset value", 0, q);
			acc(0, ra[i], 64'hA5A5_0000_5A5A_0001 + i);
			acc(1, ra[i], 0);
			chk("readback", 64'hA5A5_0000_5A5A_0001 + i, q);
		end
		chk("check control", 64'hA5A5_0000_5A5A_0003, gchk_ctl);
		acc(0, `A_FW_TRIG, 64'h0000_0000_0001_2340);
		chk("update address", 64'h0000_0000_0001_2340, fw_update_addr);
		acc(1, `A_LEGACY_ADDR, 0);
		chk("legacy address", 64'h1234_5678_9ABC_DEF0, q);
		acc(0, `A_EVSEL1, 64'hFFFF_FFFF_FFFF_FFFF);
		acc(1, `A_EVSEL1, 0);
		chk("selector one", 64'hFFBF_FFFF, q);
		acc(0, `A_EVSEL1, 0);
	endtask
	task automatic t_bus;
		acc(0, `A_BUS_CFG, 64'hFFFF_FFFF);
		chk("bus ctl", 64'hDF, bus_cfg_ctl);
		acc(1, `A_BUS_CFG, 0);
		chk("bus config", 64'h0552_A5DF, q);
		acc(0, `A_BUS_CFG, 64'h01);
		chk("bus ctl", 64'h01, bus_cfg_ctl);
	endtask
	task automatic t_debug;
		acc(0, `A_DEBUG_CTL, 64'h03);
		chk("debug outputs", 64'h3, {branch_trap, lbr_enable});
		bp_match = 2'b10;
		@(negedge clk_sys);
		chk("dual pins", 64'h2, bp_pin);
		bp_match = 2'b00;
	endtask
	task automatic t_intc;
		acc(0, `A_INTC_BASE, 64'h0100);
		chk("intc enable", 0, intc_enable);
		acc(0, `A_INTC_BASE, 64'h0800);
		acc(1, `A_INTC_BASE, 0);
		chk("intc base", 64'h0100, q);
		rst = 1'b1;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("intc enable", 1, intc_enable);
	endtask
	// inverted threshold case last: it counts idle cycles and would spill into the next case
	task automatic t_count;
		logic [31:0] sel [12] = '{32'h0047_0000, 32'h0043_0000, 32'h0046_0000, 32'h0045_0000, 32'h0007_0000,
			32'h0447_0000, 32'h0247_0000, 32'h0047_0400, 32'h0047_0200, 32'h0047_0000, 32'h0047_2000, 32'h04C7_0000};
		logic [14:0] evv [12] = '{15'h0003, 15'h0003, 15'h0003, 15'h0003, 15'h0003, 15'h0003, 15'h0003,
			15'h5003, 15'h5003, 15'h0203, 15'h0203, 15'h0003};
		logic [7:0]  ex [12] = '{8'd12, 8'd4, 8'd0, 8'd12, 8'd0, 8'd0, 8'd4, 8'd12, 8'd0, 8'd0, 8'd12, 8'd5};
		for (int i = 0; i < 12; i++) begin
			acc(0, `A_CTR0, 0);
			acc(0, `A_EVSEL0, sel[i]);
			cpl = (i == 2 || i == 3) ? 2'b11 : 2'b00;
			ev0 = evv[i];
			repeat (4) @(negedge clk_sys);
			ev0 = '0;
			acc(1, `A_CTR0, 0);
			chk("count", ex[i], q);
		end
	endtask
	task automatic t_ovf;
		acc(0, `A_EVSEL0, 64'h005F_0000);
		acc(0, `A_DEBUG_CTL, 64'h04);
		acc(0, `A_CTR0, 64'hFE);
		ev0 = 15'h0003;
		@(negedge clk_sys);
		ev0 = '0;
		@(negedge clk_sys);
		chk("overflow pin", 64'h1, bp_pin);
		chk("overflow intr", 64'h1, perf_intc_req);
		@(negedge clk_sys);
		chk("overflow end", 0, {bp_pin, perf_intc_req});
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		t_map;
		t_bus;
		t_debug;
		t_intc;
		t_count;
		t_ovf;
		stop_test;
	end
	initial begin
		#20000;
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
